// file: hw/ddr_read_capture.v
// ddr read data capture, alignment and retiming onto core_clk
`timescale 1ns/100ps
`include "ddr_capture_consts.vh"
module ddr_read_capture (
	core_clk,
	nrst,
	dqs_in,
	dq_in,
	rd_word_q,
	rd_valid_q
);
	input wire core_clk;
	input wire nrst;
	input wire dqs_in;
	input wire [`DQ_WIDTH-1:0] dq_in;
	output reg [`WORD_WIDTH-1:0] rd_word_q;
	output reg rd_valid_q;

	// ----------------------------------------
	// strobe sampling
	// ----------------------------------------
	wire dqs_inv;
	wire inv_rise;
	wire inv_fall;

	// strobe used inverted so the closing edge becomes a rising one
	assign dqs_inv = ~dqs_in;

	edge_sync u_strobe_sync (
		.core_clk(core_clk),
		.nrst(nrst),
		.pin_in(dqs_inv),
		.level_q(),
		.rise_q(inv_rise),
		.fall_q(inv_fall)
	);

	// ----------------------------------------
	// data delay matched to strobe sync depth
	// ----------------------------------------
	// limitation: data must hold for the sync latency, so the strobe
	// must be slow against core_clk (bench uses 125 ns)
	// each stage feeds the next one or the capture, so none is left unread
	reg [`DQ_WIDTH-1:0] dq_pipe_q [0:`SYNC_STAGES-1];
	genvar gi;
	always @(posedge core_clk) begin
		if (!nrst)
			dq_pipe_q[0] <= {`DQ_WIDTH{1'b0}};
		else
			dq_pipe_q[0] <= dq_in;
	end
	generate
		for (gi = 1; gi < `SYNC_STAGES; gi = gi + 1) begin : g_dq
			always @(posedge core_clk) begin
				if (!nrst)
					dq_pipe_q[gi] <= {`DQ_WIDTH{1'b0}};
				else
					dq_pipe_q[gi] <= dq_pipe_q[gi-1];
			end
		end
	endgenerate

	// ----------------------------------------
	// capture and alignment registers
	// ----------------------------------------
	reg [`DQ_WIDTH-1:0] cap_hi_q;
	reg [`DQ_WIDTH-1:0] cap_lo_q;
	reg [`DQ_WIDTH-1:0] align_lo_q;
	reg pair_q;

	// data taken one edge after the strobe edge was seen; 3 data stages against 4 on the strobe
	always @(posedge core_clk) begin
		if (!nrst) begin
			cap_hi_q <= {`DQ_WIDTH{1'b0}};
			cap_lo_q <= {`DQ_WIDTH{1'b0}};
			align_lo_q <= {`DQ_WIDTH{1'b0}};
			pair_q <= 1'b0;
		end else begin
			pair_q <= 1'b0;
			if (inv_rise) begin
				cap_hi_q <= dq_pipe_q[`SYNC_STAGES-1];
				align_lo_q <= cap_lo_q;
				pair_q <= 1'b1;
			end
			if (inv_fall)
				cap_lo_q <= dq_pipe_q[`SYNC_STAGES-1];
		end
	end

	// ----------------------------------------
	// retiming onto core clock
	// ----------------------------------------
	// one cycle after the pair appears both halves are stable;
	// the two halves of rd_word_q come from cap_hi_q and align_lo_q
	always @(posedge core_clk) begin
		if (!nrst) begin
			rd_word_q <= {`WORD_WIDTH{1'b0}};
			rd_valid_q <= 1'b0;
		end else begin
			rd_valid_q <= 1'b0;
			if (pair_q) begin
				// falling-edge word in upper half
				rd_word_q <= {cap_hi_q, align_lo_q};
				rd_valid_q <= 1'b1;
			end
		end
	end
endmodule // ddr_read_capture

// file: hw/ddr_capture_consts.vh
// constants for the ddr read capture path
`ifndef DDR_CAPTURE_CONSTS_VH
`define DDR_CAPTURE_CONSTS_VH
`define DQ_WIDTH 8
`define WORD_WIDTH 16
`define SYNC_STAGES 3
`endif

// file: hw/edge_sync.v
// three-stage synchroniser with edge detection for one pin
`timescale 1ns/100ps
module edge_sync (
	core_clk,
	nrst,
	pin_in,
	level_q,
	rise_q,
	fall_q
);
	input wire core_clk;
	input wire nrst;
	input wire pin_in;
	output reg level_q;
	output reg rise_q;
	output reg fall_q;

	reg meta_q;
	reg s2_q;
	reg s3_q;

	// ----------------------------------------
	// sync chain; first stage feeds only s2_q
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!nrst) begin
			meta_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			meta_q <= pin_in;
			s2_q <= meta_q;
			s3_q <= s2_q;
			// a change counts once stage two and three agree
			rise_q <= 1'b0;
			fall_q <= 1'b0;
			if (s2_q == s3_q && s3_q != level_q) begin
				level_q <= s3_q;
				rise_q <= s3_q;
				fall_q <= ~s3_q;
			end
		end
	end
endmodule // edge_sync

// file: verification/ddr_read_capture_chk.sv
// port assertions for the ddr read capture path
`timescale 1ns/100ps
module ddr_read_capture_chk (
	input wire core_clk,
	input wire nrst,
	input wire dqs_in,
	input wire [7:0] dq_in,
	input wire [15:0] rd_word_q,
	input wire rd_valid_q
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// windows allow two cycles of sync jitter either way
	one_pulse_a: assert property (rd_valid_q |=> !rd_valid_q) else $error("long");
	word_hold_a: assert property (!rd_valid_q |-> $stable(rd_word_q)) else $error("moved");
	fall_valid_a: assert property ($fell(dqs_in) |-> ##[4:8] rd_valid_q) else $error("none");
	valid_cause_a: assert property (rd_valid_q |-> $past(dqs_in, 8) && !$past(dqs_in, 4))
		else $error("edge");
	hi_data_a: assert property (rd_valid_q |-> rd_word_q[15:8] == $past(dq_in, 5))
		else $error("high");
	lo_data_a: assert property (rd_valid_q && !$past(dqs_in, 15) |->
		rd_word_q[7:0] == $past(dq_in, 11)) else $error("low");
	reset_zero_a: assert property (disable iff (1'b0) !nrst |=> !rd_valid_q && rd_word_q == 16'h0000)
		else $error("reset");
endmodule // ddr_read_capture_chk
bind ddr_read_capture ddr_read_capture_chk ddr_read_capture_chk_inst (.core_clk, .nrst, .dqs_in,
	.dq_in, .rd_word_q, .rd_valid_q);

// file: verification/ddr_sdram_model.sv
// memory side: strobe and data of a read burst
`timescale 1ns/100ps
module ddr_sdram_model (
	input wire run,
	input wire [7:0] word_in,
	output reg dqs_in,
	output reg [7:0] dq_in
);
	initial {dqs_in, dq_in} = 9'h100;
	// data moves mid-phase; idle strobe parks high, idle data flips
	always begin
		#31.25 dq_in = run ? word_in : ~dq_in;
		#31.25 if (run || !dqs_in) dqs_in = ~dqs_in;
	end
endmodule // ddr_sdram_model

// file: verification/testbench.sv
// self-checking bench for the ddr read capture path
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module testbench;
	logic core_clk = 0, nrst = 0, run = 0, skip = 1;
	logic [7:0] word_in = 8'h00, lo = 8'h00;
	wire dqs_in, rd_valid_q;
	wire [7:0] dq_in;
	wire [15:0] rd_word_q;
	logic [15:0] eq[$];
	int num_errors = 0, compares = 0;
	always #5 core_clk = ~core_clk;
	ddr_sdram_model ddr_sdram_model_inst (.run, .word_in, .dqs_in, .dq_in);
	ddr_read_capture ddr_read_capture_inst (.core_clk, .nrst, .dqs_in, .dq_in, .rd_word_q,
		.rd_valid_q);
	// rise word is low half, fall word high half
	always @(posedge dqs_in) lo = dq_in;
	always @(negedge dqs_in) eq.push_back({dq_in, lo});
	// first pair after reset has no known low word
	always @(posedge core_clk) if (rd_valid_q === 1'b1) begin
		if (!skip) `CHK(rd_word_q, eq[0])
		skip = 0;
		void'(eq.pop_front());
	end
	task end_sim;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// burst 0 flips every bit each core_clk cycle, burst 1 is random
	initial begin
		void'($urandom(36));
		for (int k = 0; k < 2; k++) begin
			nrst <= 0;
			skip = 1;
			repeat (5) @(posedge core_clk);
			nrst <= 1;
			repeat (2) @(posedge core_clk);
			run <= 1;
			repeat (300) begin
				@(posedge core_clk);
				word_in <= k ? 8'($urandom) : ~word_in;
			end
			run <= 0;
			repeat (30) @(posedge core_clk);
		end
		`CHK(eq.size(), 0)
		end_sim;
	end
endmodule // testbench
